// ### delay_ramp.v
/*
 * Coarse delay ramp controller: walks the active coarse delay one step at
 * a time toward the written target at the selected rate.
 * Assumes target and load come from registers in the same clock domain.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ref_cal_defines.vh"

module delay_ramp #(
	parameter W = 8
) (
	// Clock and reset
	input wire clk_i,
	input wire resetn_i,
	// Control
	input wire [W-1:0] target_i,
	input wire load_i,
	input wire enable_i,
	input wire fast_i,
	// Status
	output reg [W-1:0] active_o,
	output wire busy_o
);

	reg [7:0] div;
	wire [7:0] last = fast_i ? `RAMP_FAST_LAST : `RAMP_SLOW_LAST;

	assign busy_o = enable_i && (active_o != target_i);

	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			active_o <= {W{1'b0}};
			div <= 8'h00;
		end else if (!enable_i) begin
			active_o <= target_i;
			div <= 8'h00;
		end else if (load_i) begin
			div <= 8'h00;
		end else if (active_o != target_i) begin
			if (div == last) begin
				div <= 8'h00;
				// Single-step moves never pass the target
				if (active_o < target_i) begin
					active_o <= active_o + {{(W-1){1'b0}}, 1'b1};
				end else begin
					active_o <= active_o - {{(W-1){1'b0}}, 1'b1};
				end
			end else begin
				div <= div + 8'h01;
			end
		end else begin
			div <= 8'h00;
		end
	end

endmodule
`default_nettype wire

// ### ref_cal_defines.vh
/*
 * Shared constants for the reference capture and delay calibration block:
 * register indices, field positions, reset values and timing counts.
 * Assumes it is included by bare name from the design files.
 */
`ifndef REF_CAL_DEFINES_VH
`define REF_CAL_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_DELAY_CTRL 6'h00
`define IDX_CLK_CTRL 6'h01
`define IDX_CAL_ENABLE 6'h02
`define IDX_CAL_CONFIG 6'h03
`define IDX_CAL_STATUS 6'h04
`define IDX_DELAY_STATUS 6'h05
`define IDX_WIN_LOW 6'h2c
`define IDX_WIN_MID 6'h2d
`define IDX_WIN_HIGH 6'h2e

// Control and status field positions
`define FLD_FINE_LSB 0
`define FLD_COARSE_LSB 8
`define FLD_INV 16
`define FLD_RAMP_EN 17
`define FLD_RAMP_FAST 18
`define FLD_TAP_SEL_LSB 0
`define FLD_ZOOM 4
`define FLD_CAL_EN 0
`define FLD_DONE 24
`define FLD_FAIL 25
`define FLD_BUSY 26
`define FLD_WIN_VALID 25

// Reset values
`define RST_DELAY 8'h00
`define RST_TAP_SEL 4'h0
`define RST_ZOOM 1'b1
`define RST_CAL_CFG 8'h00

// Ramp: one step per 256 cycles slow, four steps per 256 cycles fast
`define RAMP_SLOW_CYCLES 256
`define RAMP_FAST_STEPS 4
`define RAMP_SLOW_LAST 8'hff
`define RAMP_FAST_LAST 8'h3f

// Window detector
`define WIN_EDGES_VALID 2'h3
`define WIN_EDGE_BITS 24'h800001

// Calibration: last settle count per trial setting, and highest coarse delay tried
`define CAL_SETTLE_LAST 8'h0f
`define COARSE_MAX 8'hff

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### ref_clock_source.sv
/* Partner model: clock source with periodic reference, tap samples and
   alignment detector answer. Assumes the block's device clock and reset. */
`timescale 1ns/1ns
`default_nettype none
module ref_clock_source #(
	parameter PERIOD = 32,
	parameter ALIGN_NORM = 40,
	parameter ALIGN_INV = 12
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// Applied delay
	input wire logic delay_inv_i,
	input wire logic [7:0] delay_coarse_i,
	// Reference side
	output logic ref_o,
	output logic [23:0] taps_o,
	output logic align_o
);
	int phase;
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase <= 0;
			taps_o <= 24'h000f00;
			align_o <= 1'b0;
		end else begin
			// Continuous periodic reference
			phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
			// Taps 3 to 5 flip each period
			if (phase == 0)
				taps_o <= taps_o ^ 24'h000038;
			// Inverted clock aligns at a smaller coarse, one cycle late
			align_o <= delay_coarse_i >= (delay_inv_i ? ALIGN_INV : ALIGN_NORM);
		end
	end
	assign ref_o = resetn_i && phase < PERIOD / 2;
endmodule
`default_nettype wire

// ### sysref_capture_and_delay_cal.v
/*
 * Clock-path timing logic: AXI4-Lite register file, coarse delay ramp,
 * reference window detector and automatic delay calibration engine.
 * Assumes all inputs are synchronous to CLK_I; the analog delay line, tap
 * samplers and the alignment phase detector sit outside this module.
 */
`timescale 1ns/1ns
`default_nettype none
`include "ref_cal_defines.vh"

// Function
// - With ramping on, active coarse delay steps gradually toward the written target.
// - Rate select: one step per 256 cycles, or four steps per 256 cycles.
// - Each coarse write while ramping is on restarts a ramp to the new value.
// - A 24-bit window status marks each reference tap at timing risk with 1.
// - Window status counts as valid after three reference rising edges.
// - Window status bits 0 and 23 always read 1.
// - Capture tap select holds an index 0 to 15; upper status bits informational.
// - Zoom 0 gives coarser tap spacing, zoom 1 finer.
// - Enabled calibration searches delays until clock falling meets reference rising.
// - Calibration raises a pollable done flag when the search ends.
// - Found setting is readable and stays applied while calibration remains enabled.
// - Search tries both clock polarities and picks the smaller coarse delay.
// - Inversion bit adds half a clock period on top of coarse and fine delay.
module sysref_capture_and_delay_cal #(
	parameter TAPS = 24,
	parameter SEL_W = 4,
	parameter DW = 8
) (
	// Clock and reset
	input wire CLK_I,
	input wire RESETN_I,
	// AXI4-Lite write address and data
	input wire [7:0] AWADDR_I,
	input wire AWVALID_I,
	output wire AWREADY_O,
	input wire [31:0] WDATA_I,
	input wire [3:0] WSTRB_I,
	input wire WVALID_I,
	output wire WREADY_O,
	// AXI4-Lite write response
	output reg [1:0] BRESP_O,
	output reg BVALID_O,
	input wire BREADY_I,
	// AXI4-Lite read
	input wire [7:0] ARADDR_I,
	input wire ARVALID_I,
	output wire ARREADY_O,
	output reg [31:0] RDATA_O,
	output reg [1:0] RRESP_O,
	output reg RVALID_O,
	input wire RREADY_I,
	// Reference and tap samplers
	input wire REF_I,
	input wire [TAPS-1:0] TAP_CAPTURE_I,
	input wire ALIGN_I,
	// Delay line and capture controls
	output reg DELAY_INV_O,
	output reg [DW-1:0] DELAY_COARSE_O,
	output reg [DW-1:0] DELAY_FINE_O,
	output reg TAP_ZOOM_O,
	output reg [SEL_W-1:0] CAPTURE_TAP_O
);

	localparam CS_IDLE = 2'b00;
	localparam CS_SETTLE = 2'b01;
	localparam CS_DONE = 2'b10;

	// Software registers
	reg [DW-1:0] fine_delay_setting, coarse_delay_setting, auto_cal_config;
	reg clock_inversion_bit, ramp_enable, ramp_rate_select;
	reg [SEL_W-1:0] capture_tap_select;
	reg tap_spacing_zoom, auto_cal_enable;
	reg coarse_load, win_clear, cal_start;

	// Ramp
	wire [DW-1:0] active_coarse;
	wire ramp_busy;

	// Window detector
	reg ref_d;
	reg [1:0] edge_cnt;
	reg [TAPS-1:0] prev_cap, risk_flags;
	wire [TAPS-1:0] next_risk, reference_window_status;
	wire ref_rise = REF_I && !ref_d;
	wire window_valid = (edge_cnt == `WIN_EDGES_VALID);

	// Calibration engine
	reg [1:0] cstate;
	reg [7:0] settle_cnt;
	reg [DW-1:0] s_coarse, c0, res_coarse, res_fine;
	reg s_inv, f0, res_inv, auto_cal_done, cal_fail;
	wire cal_busy = (cstate == CS_SETTLE);

	// Bus decode
	wire wr_take = AWVALID_I && WVALID_I && !BVALID_O;
	wire [5:0] wr_idx = AWADDR_I[7:2];
	wire [5:0] rd_idx = ARADDR_I[7:2];
	reg [31:0] rd_data;
	reg rd_hit, wr_hit;

	assign AWREADY_O = wr_take;
	assign WREADY_O = wr_take;
	assign ARREADY_O = !RVALID_O;

	delay_ramp #(.W(DW)) delay_ramp_i (
		.clk_i(CLK_I), .resetn_i(RESETN_I),
		.target_i(coarse_delay_setting),
		.load_i(coarse_load),
		.enable_i(ramp_enable),
		.fast_i(ramp_rate_select),
		.active_o(active_coarse),
		.busy_o(ramp_busy)
	);

	// Register writes
	always @*begin
		if (wr_idx <= `IDX_DELAY_STATUS) begin
			wr_hit = 1'b1;
		end else if (wr_idx >= `IDX_WIN_LOW && wr_idx <= `IDX_WIN_HIGH) begin
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fine_delay_setting <= `RST_DELAY;
			coarse_delay_setting <= `RST_DELAY;
			clock_inversion_bit <= 1'b0;
			ramp_enable <= 1'b0;
			ramp_rate_select <= 1'b0;
			capture_tap_select <= `RST_TAP_SEL;
			tap_spacing_zoom <= `RST_ZOOM;
			auto_cal_enable <= 1'b0;
			auto_cal_config <= `RST_CAL_CFG;
			coarse_load <= 1'b0;
			win_clear <= 1'b0;
			cal_start <= 1'b0;
			BVALID_O <= 1'b0;
			BRESP_O <= `RESP_OKAY;
		end else begin
			coarse_load <= 1'b0;
			win_clear <= 1'b0;
			cal_start <= 1'b0;
			if (BVALID_O && BREADY_I) begin
				BVALID_O <= 1'b0;
			end
			if (wr_take) begin
				BVALID_O <= 1'b1;
				BRESP_O <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
				if (wr_idx == `IDX_DELAY_CTRL) begin
					if (WSTRB_I[0]) begin
						fine_delay_setting <= WDATA_I[`FLD_FINE_LSB +: DW];
					end
					if (WSTRB_I[1]) begin
						coarse_delay_setting <= WDATA_I[`FLD_COARSE_LSB +: DW];
						coarse_load <= 1'b1;
					end
					if (WSTRB_I[2]) begin
						clock_inversion_bit <= WDATA_I[`FLD_INV];
						ramp_enable <= WDATA_I[`FLD_RAMP_EN];
						ramp_rate_select <= WDATA_I[`FLD_RAMP_FAST];
					end
				end else if (wr_idx == `IDX_CLK_CTRL) begin
					if (WSTRB_I[0]) begin
						capture_tap_select <= WDATA_I[`FLD_TAP_SEL_LSB +: SEL_W];
						tap_spacing_zoom <= WDATA_I[`FLD_ZOOM];
						win_clear <= (WDATA_I[`FLD_ZOOM] != tap_spacing_zoom);
					end
				end else if (wr_idx == `IDX_CAL_ENABLE) begin
					if (WSTRB_I[0]) begin
						auto_cal_enable <= WDATA_I[`FLD_CAL_EN];
						cal_start <= WDATA_I[`FLD_CAL_EN] && !auto_cal_enable;
					end
				end else if (wr_idx == `IDX_CAL_CONFIG) begin
					if (WSTRB_I[0]) begin
						auto_cal_config <= WDATA_I[DW-1:0];
					end
				end
			end
		end
	end

	// Register reads
	always @*begin
		rd_data = 32'h00000000;
		rd_hit = 1'b1;
		if (rd_idx == `IDX_DELAY_CTRL) begin
			rd_data[`FLD_FINE_LSB +: DW] = fine_delay_setting;
			rd_data[`FLD_COARSE_LSB +: DW] = coarse_delay_setting;
			rd_data[`FLD_INV] = clock_inversion_bit;
			rd_data[`FLD_RAMP_EN] = ramp_enable;
			rd_data[`FLD_RAMP_FAST] = ramp_rate_select;
		end else if (rd_idx == `IDX_CLK_CTRL) begin
			rd_data[`FLD_TAP_SEL_LSB +: SEL_W] = capture_tap_select;
			rd_data[`FLD_ZOOM] = tap_spacing_zoom;
		end else if (rd_idx == `IDX_CAL_ENABLE) begin
			rd_data[`FLD_CAL_EN] = auto_cal_enable;
		end else if (rd_idx == `IDX_CAL_CONFIG) begin
			rd_data[DW-1:0] = auto_cal_config;
		end else if (rd_idx == `IDX_CAL_STATUS) begin
			rd_data[`FLD_FINE_LSB +: DW] = res_fine;
			rd_data[`FLD_COARSE_LSB +: DW] = res_coarse;
			rd_data[`FLD_INV] = res_inv;
			rd_data[`FLD_DONE] = auto_cal_done;
			rd_data[`FLD_FAIL] = cal_fail;
			rd_data[`FLD_BUSY] = cal_busy;
		end else if (rd_idx == `IDX_DELAY_STATUS) begin
			rd_data[`FLD_FINE_LSB +: DW] = DELAY_FINE_O;
			rd_data[`FLD_COARSE_LSB +: DW] = DELAY_COARSE_O;
			rd_data[`FLD_INV] = DELAY_INV_O;
			rd_data[`FLD_DONE] = ramp_busy;
			rd_data[`FLD_WIN_VALID] = window_valid;
		end else if (rd_idx == `IDX_WIN_LOW) begin
			rd_data[7:0] = reference_window_status[7:0];
		end else if (rd_idx == `IDX_WIN_MID) begin
			rd_data[7:0] = reference_window_status[15:8];
		end else if (rd_idx == `IDX_WIN_HIGH) begin
			rd_data[7:0] = reference_window_status[23:16];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			RVALID_O <= 1'b0;
			RDATA_O <= 32'h00000000;
			RRESP_O <= `RESP_OKAY;
		end else if (ARVALID_I && !RVALID_O) begin
			RVALID_O <= 1'b1;
			RDATA_O <= rd_data;
			RRESP_O <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (RVALID_O && RREADY_I) begin
			RVALID_O <= 1'b0;
		end
	end

	// Window detector: a tap whose capture changes between reference edges is flagged
	genvar i;
	generate
		for (i = 0; i < TAPS; i = i + 1) begin : g_tap
			assign next_risk[i] = (ref_rise && edge_cnt != 2'h0 &&
				TAP_CAPTURE_I[i] != prev_cap[i]) ? 1'b1 :
				(win_clear ? 1'b0 : risk_flags[i]);
		end
	endgenerate

	assign reference_window_status = risk_flags | `WIN_EDGE_BITS;

	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ref_d <= 1'b0;
			edge_cnt <= 2'h0;
			prev_cap <= {TAPS{1'b0}};
			risk_flags <= {TAPS{1'b0}};
		end else begin
			ref_d <= REF_I;
			risk_flags <= next_risk;
			if (ref_rise) begin
				prev_cap <= TAP_CAPTURE_I;
			end
			if (win_clear) begin
				edge_cnt <= 2'h0;
			end else if (ref_rise && !window_valid) begin
				edge_cnt <= edge_cnt + 2'h1;
			end
		end
	end

	// Calibration engine: sweep coarse upward per polarity until the phase
	// detector reports alignment, then keep the smaller coarse value
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cstate <= CS_IDLE;
			settle_cnt <= 8'h00;
			s_inv <= 1'b0;
			s_coarse <= {DW{1'b0}};
			c0 <= {DW{1'b0}};
			f0 <= 1'b0;
			res_inv <= 1'b0;
			res_coarse <= {DW{1'b0}};
			res_fine <= {DW{1'b0}};
			auto_cal_done <= 1'b0;
			cal_fail <= 1'b0;
		end else begin
			case (cstate)
				CS_SETTLE: begin
					if (!auto_cal_enable) begin
						cstate <= CS_IDLE;
					end else if (settle_cnt != `CAL_SETTLE_LAST) begin
						settle_cnt <= settle_cnt + 8'h01;
					end else begin
						settle_cnt <= 8'h00;
						if (ALIGN_I || s_coarse == `COARSE_MAX) begin
							if (!s_inv) begin
								c0 <= s_coarse;
								f0 <= ALIGN_I;
								s_inv <= 1'b1;
								s_coarse <= {DW{1'b0}};
							end else begin
								if (ALIGN_I && (!f0 || s_coarse < c0)) begin
									res_inv <= 1'b1;
									res_coarse <= s_coarse;
								end else begin
									res_inv <= 1'b0;
									res_coarse <= f0 ? c0 : {DW{1'b0}};
								end
								res_fine <= auto_cal_config;
								cal_fail <= !f0 && !ALIGN_I;
								auto_cal_done <= 1'b1;
								cstate <= CS_DONE;
							end
						end else begin
							s_coarse <= s_coarse + {{(DW-1){1'b0}}, 1'b1};
						end
					end
				end
				default: begin
					if (cal_start) begin
						cstate <= CS_SETTLE;
						settle_cnt <= 8'h00;
						auto_cal_done <= 1'b0;
						s_inv <= 1'b0;
						s_coarse <= {DW{1'b0}};
					end
				end
			endcase
		end
	end

	// Applied delay and capture controls
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DELAY_INV_O <= 1'b0;
			DELAY_COARSE_O <= {DW{1'b0}};
			DELAY_FINE_O <= {DW{1'b0}};
			TAP_ZOOM_O <= `RST_ZOOM;
			CAPTURE_TAP_O <= `RST_TAP_SEL;
		end else begin
			TAP_ZOOM_O <= tap_spacing_zoom;
			CAPTURE_TAP_O <= capture_tap_select;
			if (auto_cal_enable && cal_busy) begin
				DELAY_INV_O <= s_inv;
				DELAY_COARSE_O <= s_coarse;
				DELAY_FINE_O <= auto_cal_config;
			end else if (auto_cal_enable && auto_cal_done) begin
				DELAY_INV_O <= res_inv;
				DELAY_COARSE_O <= res_coarse;
				DELAY_FINE_O <= res_fine;
			end else begin
				DELAY_INV_O <= clock_inversion_bit;
				DELAY_COARSE_O <= active_coarse;
				DELAY_FINE_O <= fine_delay_setting;
			end
		end
	end

endmodule
`default_nettype wire

// ### sysref_capture_and_delay_cal_assertions.sv
/* Checker for the register bus, window status and coarse ramp.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module ref_cal_checker #(
	parameter SEL_W = 4,
	parameter DW = 8
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// Write channels
	input wire logic [7:0] AWADDR_I,
	input wire logic AWVALID_I,
	input wire logic AWREADY_O,
	input wire logic WREADY_O,
	input wire logic [31:0] WDATA_I,
	input wire logic WVALID_I,
	input wire logic [1:0] BRESP_O,
	input wire logic BVALID_O,
	input wire logic BREADY_I,
	// Read channels
	input wire logic [7:0] ARADDR_I,
	input wire logic ARVALID_I,
	input wire logic ARREADY_O,
	input wire logic [31:0] RDATA_O,
	input wire logic [1:0] RRESP_O,
	input wire logic RVALID_O,
	input wire logic RREADY_I,
	// Reference and delay
	input wire logic REF_I,
	input wire logic [DW-1:0] DELAY_COARSE_O,
	input wire logic TAP_ZOOM_O,
	input wire logic [SEL_W-1:0] CAPTURE_TAP_O
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	function automatic logic mapped(input logic [7:0] a);
		mapped = a[7:2] <= 6'h05 || (a[7:2] >= 6'h2c && a[7:2] <= 6'h2e);
	endfunction
	wire wr_take = AWVALID_I && WVALID_I && AWREADY_O;
	wire rd_take = ARVALID_I && ARREADY_O;
	wire wr_map = mapped(AWADDR_I);
	wire rd_map = mapped(ARADDR_I);
	logic ramp_on, fast, ref_d;
	logic [1:0] edges;
	logic [8:0] gap;
	logic [DW-1:0] last;
	wire moved = ramp_on && DELAY_COARSE_O != last;
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ramp_on <= 1'b0;
			fast <= 1'b0;
			ref_d <= 1'b0;
			edges <= 2'h0;
			gap <= 9'h000;
			last <= {DW{1'b0}};
		end else begin
			if (wr_take && AWADDR_I == 8'h00) begin
				ramp_on <= WDATA_I[17];
				fast <= WDATA_I[18];
			end
			ref_d <= REF_I;
			if (REF_I && !ref_d && edges != 2'h3)
				edges <= edges + 2'h1;
			last <= DELAY_COARSE_O;
			gap <= (DELAY_COARSE_O != last) ? 9'h000 : gap + {8'h00, gap != 9'h1ff};
		end
	end
	sequence resp_held;
		BVALID_O && !BREADY_I;
	endsequence
	sequence data_held;
		RVALID_O && !RREADY_I;
	endsequence
	write_answer_a: assert property (wr_take |=> BVALID_O && BRESP_O == ($past(wr_map) ? 2'h0 : 2'h2))
		else $error("write response wrong");
	bresp_hold_a: assert property (resp_held |=> BVALID_O && $stable(BRESP_O))
		else $error("write response dropped");
	read_answer_a: assert property (rd_take |=> RVALID_O && RRESP_O == ($past(rd_map) ? 2'h0 : 2'h2))
		else $error("read response wrong");
	rdata_hold_a: assert property (data_held |=> RVALID_O && $stable(RDATA_O))
		else $error("read data dropped");
	write_ready_a: assert property (WREADY_O == AWREADY_O && AWREADY_O == (AWVALID_I && WVALID_I && !BVALID_O))
		else $error("write ready wrong");
	window_ends_a: assert property (rd_take && ARADDR_I == 8'hb0 |=> RDATA_O[0] && RDATA_O[31:8] == 24'h0)
		else $error("window low end wrong");
	window_valid_a: assert property (rd_take && ARADDR_I == 8'h14 && edges != 2'h3 |=> !RDATA_O[25])
		else $error("window valid too early");
	tap_select_a: assert property (wr_take && AWADDR_I == 8'h04 |-> ##2 CAPTURE_TAP_O == $past(WDATA_I[SEL_W-1:0], 2))
		else $error("capture tap not applied");
	zoom_apply_a: assert property (wr_take && AWADDR_I == 8'h04 |-> ##2 TAP_ZOOM_O == $past(WDATA_I[4], 2))
		else $error("zoom not applied");
	ramp_step_a: assert property (moved |-> DELAY_COARSE_O == last + 1'b1 || last == DELAY_COARSE_O + 1'b1)
		else $error("ramp step not one");
	ramp_rate_a: assert property (moved |-> gap >= (fast ? 9'h03e : 9'h0fe))
		else $error("ramp step too soon");
endmodule
bind sysref_capture_and_delay_cal ref_cal_checker #(.SEL_W(SEL_W), .DW(DW)) ref_cal_checker_i (.*);
`default_nettype wire

// ### sysref_capture_and_delay_cal_test.sv
/* Bench: register bus master, window, zoom, ramp and calibration runs.
   Assumes the clock source partner model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module sysref_capture_and_delay_cal_test;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, b;
	logic [31:0] wdata = 32'h0, got;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire awready, wready, bvalid, arready, rvalid, ref_s, align, inv, zoom;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [23:0] taps;
	wire [7:0] coarse, fine;
	wire [3:0] tap;
	int errors = 0, n_checks = 0, seed = 32'hba47, k;
	logic [1:0] resp;
	logic [3:0] wstrb = 4'hf;
	logic [3:0] sel;
	logic zm, zprev;
	initial begin
		forever #50 clk = ~clk;
	end
	sysref_capture_and_delay_cal sysref_capture_and_delay_cal_i (
		.CLK_I(clk), .RESETN_I(resetn),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.REF_I(ref_s), .TAP_CAPTURE_I(taps), .ALIGN_I(align),
		.DELAY_INV_O(inv), .DELAY_COARSE_O(coarse), .DELAY_FINE_O(fine),
		.TAP_ZOOM_O(zoom), .CAPTURE_TAP_O(tap));
	ref_clock_source ref_clock_source_i (
		.clk_i(clk), .resetn_i(resetn), .delay_inv_i(inv), .delay_coarse_i(coarse),
		.ref_o(ref_s), .taps_o(taps), .align_o(align));
	task tally_and_finish();
		if (errors == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task guard(inout int n);
		n++;
		if (n > 20000) begin
			errors++;
			tally_and_finish();
		end
	endtask
	task cyc(input int c);
		repeat (c) @(posedge clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
		end while (!rvalid);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(got & m, e);
	endtask
	// Delay control word with fine fixed at 5
	function automatic logic [31:0] dctl(input logic [7:0] c, input logic f, input logic e);
		dctl = {13'h0, f, e, 1'b0, c, 8'h05};
	endfunction
	// Partner flips taps 3 to 5; both ends always flagged
	function automatic logic [31:0] win_byte(input int i);
		logic [23:0] w;
		w = 24'h000038 | 24'h800001;
		win_byte = {24'h0, w[8*i +: 8]};
	endfunction
	initial begin
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rchk(8'h14, 32'h0200_0000, 32'h0);
		rchk(8'h04, 32'hffff_ffff, 32'h10);
		wr(8'h40, 32'h1);
		chk(resp, 32'h2);
		rchk(8'h40, 32'hffff_ffff, 32'h0);
		chk(resp, 32'h2);
		cyc(120);
		for (int i = 0; i < 3; i++)
			rchk(8'hb0 + 8'(4 * i), 32'hffff_ffff, win_byte(i));
		wr(8'hb0, 32'h0);
		rchk(8'hb0, 32'hffff_ffff, win_byte(0));
		rchk(8'h14, 32'h0200_0000, 32'h0200_0000);
		zprev = 1'b1;
		for (int i = 0; i < 6; i++) begin
			sel = (i == 0) ? 4'hf : (i == 1) ? 4'h1 : 4'($random(seed));
			zm = 1'($random(seed));
			wr(8'h04, {27'h0, zm, sel});
			cyc(2);
			chk({zoom, tap}, {zm, sel});
			if (zm != zprev)
				rchk(8'h14, 32'h0200_0000, 32'h0);
			zprev = zm;
		end
		wr(8'h04, 32'h10);
		b = 8'h14 + 8'($random(seed) & 32'h3f);
		wr(8'h00, dctl(b, 1'b0, 1'b0));
		cyc(3);
		chk({coarse, fine}, {b, 8'h05});
		wstrb <= 4'h1;
		wr(8'h00, 32'h0000_ff09);
		wstrb <= 4'hf;
		cyc(2);
		chk({coarse, fine}, {b, 8'h09});
		wr(8'h00, dctl(b + 8'h03, 1'b1, 1'b1));
		cyc(100);
		chk(coarse, b + 8'h01);
		cyc(150);
		chk(coarse, b + 8'h03);
		wr(8'h00, dctl(b, 1'b0, 1'b1));
		cyc(400);
		chk(coarse, b + 8'h02);
		wr(8'h00, dctl(b + 8'h01, 1'b0, 1'b1));
		cyc(150);
		chk(coarse, b + 8'h02);
		cyc(150);
		chk(coarse, b + 8'h01);
		wr(8'h00, 32'h0);
		wr(8'h0c, 32'h33);
		wr(8'h08, 32'h1);
		k = 0;
		got = 32'h0;
		while (!got[24]) begin
			rd(8'h10);
			guard(k);
		end
		chk(got, 32'h0101_0c33);
		cyc(50);
		chk({inv, coarse, fine}, 32'h1_0c33);
		rchk(8'h14, 32'h0001_ffff, 32'h1_0c33);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h0001_0c33);
		cyc(3);
		chk({inv, coarse, fine}, 32'h1_0c33);
		tally_and_finish();
	end
endmodule
`default_nettype wire
